// file: rtl/fault_action_pkg.sv
package fault_action_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FAULT = 8'h04;
   localparam logic [7:0] OFS_ACTION = 8'h08;
   localparam logic [7:0] OFS_CHAN_ALM = 8'h0C;
   localparam logic [7:0] OFS_BLOCK = 8'h10;

   // Control register field positions.
   localparam int CTRL_SRC_LO = 0;
   localparam int CTRL_SRC_HI = 1;
   localparam int CTRL_FREERUN_EN = 2;
   localparam int CTRL_REG_PRESENT = 3;
   localparam int CTRL_AIS_FRAME = 4;
   localparam int CTRL_TDMA_NOBUF = 5;
   localparam int CTRL_SYS_REMOTE = 6;
   localparam int CTRL_SYS_AIS = 7;
   localparam int CTRL_SYS_BLOCK = 8;
   localparam int CTRL_SYS_PILOT = 9;
   localparam int CTRL_PWR_PILOT = 10;
   localparam int CTRL_ERR_HIGH = 11;
   localparam int CTRL_WIDTH = 12;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 12'h004;

   // Fault vector bit positions.
   localparam int F_LOS = 0;
   localparam int F_LOF = 1;
   localparam int F_ERR = 2;
   localparam int F_RAI = 3;
   localparam int F_AIS = 4;
   localparam int F_PILOT0 = 5;
   localparam int F_PILOT1 = 6;
   localparam int F_LVL = 7;
   localparam int F_PWR = 8;
   localparam int F_SYS = 9;
   localparam int F_SYNC = 10;
   localparam int F_WIDTH = 11;

   // Channel and group layout.
   localparam int NUM_CHAN = 24;
   localparam int GROUP_CHAN = 12;
   localparam int NUM_GROUP = 2;

   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'b00,
      SRC_EXTERNAL = 2'b01,
      SRC_PCM = 2'b10,
      SRC_FREERUN = 2'b11
   } clk_src_t;

   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_WRESP = 2'b01,
      AX_RDATA = 2'b10
   } ax_state_t;

endpackage

// file: rtl/fault_action_if.sv
interface fault_action_if;
   import fault_action_pkg::*;
   logic [F_WIDTH-1:0] fault;
   logic [CTRL_WIDTH-1:0] ctrl;
   logic [NUM_CHAN-1:0] chan_alarm;
   logic prompt_alarm;
   logic remote_alarm;
   logic ais_send;
   logic [NUM_CHAN-1:0] block_pcm_fdm;
   logic [NUM_CHAN-1:0] block_fdm_pcm;
   logic pilot_cut;
   modport matrix (input fault, input ctrl, input chan_alarm, output prompt_alarm,
      output remote_alarm, output ais_send, output block_pcm_fdm, output block_fdm_pcm,
      output pilot_cut);
   modport top (output fault, output ctrl, output chan_alarm, input prompt_alarm,
      input remote_alarm, input ais_send, input block_pcm_fdm, input block_fdm_pcm,
      input pilot_cut);
endinterface

// file: rtl/action_matrix.sv
module action_matrix
   import fault_action_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Fault and action carrier
   fault_action_if.matrix fa
);

   typedef struct packed {
      logic prompt;
      logic remote;
      logic ais;
      logic [NUM_CHAN-1:0] blk_pf;
      logic [NUM_CHAN-1:0] blk_fp;
      logic cut;
   } mat_state_t;

   mat_state_t s_r;
   mat_state_t s_nxt;

   always_comb begin
      logic ais_rx;
      logic pcm_fail;
      logic sys;
      logic [NUM_CHAN-1:0] pilot_ch;
      ais_rx = fa.fault[F_AIS] & fa.ctrl[CTRL_AIS_FRAME];
      pcm_fail = fa.fault[F_LOS] | fa.fault[F_LOF];
      sys = fa.fault[F_SYS];
      // Channels 1-12 follow group 1, 13-24 group 2.
      pilot_ch = {{GROUP_CHAN{fa.fault[F_PILOT1]}}, {GROUP_CHAN{fa.fault[F_PILOT0]}}};
      s_nxt = s_r;
      // Each action is the OR of its causes and drops once they have cleared.
      s_nxt.prompt = (~ais_rx & (pcm_fail | fa.fault[F_ERR]))
         | fa.fault[F_RAI]
         | ais_rx
         | fa.fault[F_PILOT0] | fa.fault[F_PILOT1]
         | (fa.fault[F_LVL] & fa.ctrl[CTRL_REG_PRESENT])
         | fa.fault[F_PWR]
         | sys
         | fa.fault[F_SYNC];
      s_nxt.remote = pcm_fail | fa.fault[F_ERR]
         | (sys & fa.ctrl[CTRL_SYS_REMOTE]);
      s_nxt.blk_pf = {NUM_CHAN{pcm_fail | ais_rx | (sys & fa.ctrl[CTRL_SYS_BLOCK])}};
      s_nxt.blk_fp = pilot_ch | {NUM_CHAN{sys & fa.ctrl[CTRL_SYS_BLOCK]}};
      // AIS only when every channel of the stream is in alarm, or on system failure with CTRL_SYS_AIS set.
      s_nxt.ais = (&(fa.chan_alarm | pilot_ch)) | (sys & fa.ctrl[CTRL_SYS_AIS]);
      s_nxt.cut = (fa.fault[F_PWR] & fa.ctrl[CTRL_PWR_PILOT])
         | (sys & fa.ctrl[CTRL_SYS_PILOT]);
      if (!aresetn) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign fa.prompt_alarm = s_r.prompt;
   assign fa.remote_alarm = s_r.remote;
   assign fa.ais_send = s_r.ais;
   assign fa.block_pcm_fdm = s_r.blk_pf;
   assign fa.block_fdm_pcm = s_r.blk_fp;
   assign fa.pilot_cut = s_r.cut;

   property p_rai_only_prompt;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault == (F_WIDTH'(1) << F_RAI) && fa.chan_alarm != '1) |=> (fa.prompt_alarm
         && !fa.remote_alarm && !fa.ais_send && fa.block_pcm_fdm == '0 && !fa.pilot_cut);
   endproperty
   a_rai_only_prompt: assert property (p_rai_only_prompt) else $error("rai misaction");

   property p_lof_actions;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault[F_LOF] && !fa.fault[F_AIS]) |=> (fa.prompt_alarm && fa.remote_alarm
         && &fa.block_pcm_fdm);
   endproperty
   a_lof_actions: assert property (p_lof_actions) else $error("lof actions missing");

   property p_ais_suppress;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault == ((F_WIDTH'(1) << F_AIS) | (F_WIDTH'(1) << F_ERR))
         && !fa.ctrl[CTRL_AIS_FRAME]) |=> fa.prompt_alarm;
   endproperty
   a_ais_suppress: assert property (p_ais_suppress) else $error("err alarm lost");

   property p_pilot_block;
      @(posedge aclk) disable iff (!aresetn)
      fa.fault[F_PILOT0] |=> (fa.block_fdm_pcm[GROUP_CHAN-1:0] == '1 && fa.prompt_alarm);
   endproperty
   a_pilot_block: assert property (p_pilot_block) else $error("pilot block missing");

   property p_ais_all;
      @(posedge aclk) disable iff (!aresetn)
      (fa.chan_alarm == '1) |=> fa.ais_send;
   endproperty
   a_ais_all: assert property (p_ais_all) else $error("ais not sent");

   property p_lvl_gate;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault == (F_WIDTH'(1) << F_LVL))
         |=> (fa.prompt_alarm == $past(fa.ctrl[CTRL_REG_PRESENT]));
   endproperty
   a_lvl_gate: assert property (p_lvl_gate) else $error("level alarm gating");

   property p_pwr;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault[F_PWR] && !fa.fault[F_SYS])
         |=> (fa.prompt_alarm && fa.pilot_cut == $past(fa.ctrl[CTRL_PWR_PILOT]));
   endproperty
   a_pwr: assert property (p_pwr) else $error("power actions");

   property p_clear;
      @(posedge aclk) disable iff (!aresetn)
      (fa.fault == '0 && fa.chan_alarm != '1) [*2] |=> (!fa.prompt_alarm && !fa.remote_alarm);
   endproperty
   a_clear: assert property (p_clear) else $error("alarm not cleared");

   property p_sync;
      @(posedge aclk) disable iff (!aresetn)
      fa.fault[F_SYNC] |=> fa.prompt_alarm;
   endproperty
   a_sync: assert property (p_sync) else $error("sync alarm missing");

   c_lof: cover property (@(posedge aclk) disable iff (!aresetn)
      fa.fault[F_LOF] ##1 fa.remote_alarm);
   c_ais: cover property (@(posedge aclk) disable iff (!aresetn) fa.ais_send);
   c_cut: cover property (@(posedge aclk) disable iff (!aresetn) fa.pilot_cut);

endmodule

// file: rtl/transmultiplexer_unit.sv
// What this block does
// - PCM channels 1-12 map to group 1, channels 13-24 to group 2.
// - Timing comes from internal clock, external reference, or incoming PCM.
// - On external reference loss, the locked oscillator may keep running free.
// - Local alarm on synchronization system fault or missing external reference.
// - TDMA without Doppler buffers times outgoing streams from terminal sync.
// - An action is raised when any active fault calls for it.
// - Frame loss or signal loss: prompt alarm, remote alarm, block PCM-to-FDM.
// - Excess error ratio: prompt alarm and remote alarm; threshold selectable.
// - Remote alarm received: prompt alarm only.
// - Remote alarm travels in data link bits, read alike at both ends.
// - AIS received: prompt alarm and PCM-to-FDM blocking, where framing allows.
// - During AIS, suppress prompt alarms from frame loss, signal loss, errors.
// - Missing group pilot: prompt alarm, block its channels; they count as alarmed for AIS.
// - Send AIS only when all 24 channels of the stream alarm, or on system failure with CTRL_SYS_AIS set.
// - Pilot level deviation alarm only when level regulation is present.
// - Power failure: prompt alarm, optionally cut pilot toward remote terminal.
// - System failure: prompt alarm; further actions chosen per application.
// - Behave as a peer multiplex toward PCM and peer translator toward FDM.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
module transmultiplexer_unit
   import fault_action_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Fault detector inputs (from pins, asynchronous)
   input wire logic los_in,
   input wire logic lof_in,
   input wire logic err_e4_in,
   input wire logic err_e3_in,
   input wire logic rai_in,
   input wire logic ais_in,
   input wire logic [1:0] pilot_absent_in,
   input wire logic pilot_level_in,
   input wire logic power_fail_in,
   input wire logic system_fail_in,
   input wire logic sync_fault_in,
   input wire logic ext_ref_present_in,
   input wire logic pcm_lock_in,
   input wire logic tdma_sync_present_in,
   input wire logic [23:0] chan_alarm_in,
   // Consequent actions
   output logic prompt_alarm,
   output logic remote_alarm_dl,
   output logic ais_send,
   output logic [23:0] block_pcm_fdm,
   output logic [23:0] block_fdm_pcm,
   output logic pilot_cut,
   output logic local_alarm,
   output logic [1:0] clk_src_sel
);

   localparam int NSYNC = 15 + NUM_CHAN;

   typedef struct packed {
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic [CTRL_WIDTH-1:0] ctrl;
      ax_state_t ax;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [1:0] src;
      logic local_alm;
   } top_state_t;

   top_state_t s_r;
   top_state_t s_nxt;
   fault_action_if fa ();

   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] sy;
   logic ext_ok;
   logic pcm_ok;
   logic tdma_ok;
   logic [F_WIDTH-1:0] fault_v;

   assign raw = {chan_alarm_in, tdma_sync_present_in, pcm_lock_in, ext_ref_present_in,
      sync_fault_in, system_fail_in, power_fail_in, pilot_level_in, pilot_absent_in, ais_in,
      rai_in, err_e3_in, err_e4_in, lof_in, los_in};
   assign sy = s_r.s2;
   assign ext_ok = sy[12];
   assign pcm_ok = sy[13];
   assign tdma_ok = sy[14];

   // The selected threshold picks which error detector counts.
   always_comb begin
      fault_v = '0;
      fault_v[F_LOS] = sy[0];
      fault_v[F_LOF] = sy[1];
      fault_v[F_ERR] = s_r.ctrl[CTRL_ERR_HIGH] ? sy[3] : sy[2];
      fault_v[F_RAI] = sy[4];
      fault_v[F_AIS] = sy[5];
      fault_v[F_PILOT0] = sy[6];
      fault_v[F_PILOT1] = sy[7];
      fault_v[F_LVL] = sy[8];
      fault_v[F_PWR] = sy[9];
      fault_v[F_SYS] = sy[10];
      fault_v[F_SYNC] = s_r.local_alm;
   end

   assign fa.fault = fault_v;
   assign fa.ctrl = s_r.ctrl;
   assign fa.chan_alarm = sy[NSYNC-1:15];

   action_matrix u_matrix (
      .aclk(aclk),
      .aresetn(aresetn),
      .fa(fa.matrix)
   );

   always_comb begin
      logic [1:0] req;
      logic aw_take;
      logic w_take;
      s_nxt = s_r;
      req = s_r.ctrl[CTRL_SRC_HI:CTRL_SRC_LO];
      aw_take = s_axi_awvalid & ~s_r.aw_got & (s_r.ax == AX_IDLE);
      w_take = s_axi_wvalid & ~s_r.w_got & (s_r.ax == AX_IDLE);
      // Two-stage synchroniser; only stage two feeds logic.
      s_nxt.s1 = raw;
      s_nxt.s2 = s_r.s1;

      // Timing source selection with free-run fallback.
      if (s_r.ctrl[CTRL_TDMA_NOBUF]) begin
         s_nxt.src = tdma_ok ? SRC_EXTERNAL : SRC_FREERUN;
      end else if (req == SRC_EXTERNAL) begin
         s_nxt.src = ext_ok ? SRC_EXTERNAL
            : (s_r.ctrl[CTRL_FREERUN_EN] ? SRC_FREERUN : SRC_INTERNAL);
      end else if (req == SRC_PCM) begin
         // Without lock the remote end is expected to loop its timing.
         s_nxt.src = pcm_ok ? SRC_PCM : SRC_INTERNAL;
      end else begin
         s_nxt.src = SRC_INTERNAL;
      end
      s_nxt.local_alm = sy[11] | (req == SRC_EXTERNAL & ~ext_ok)
         | (s_r.ctrl[CTRL_TDMA_NOBUF] & ~tdma_ok);

      // AXI4-Lite write: address and data taken in either order.
      if (aw_take) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      case (s_r.ax)
         AX_IDLE: begin
            if (s_r.aw_got && s_r.w_got) begin
               s_nxt.aw_got = 1'b0;
               s_nxt.w_got = 1'b0;
               s_nxt.ax = AX_WRESP;
               s_nxt.resp = 2'h2;
               if (s_r.awaddr == OFS_CTRL) begin
                  s_nxt.resp = 2'h0;
                  if (s_r.wstrb[0]) begin
                     s_nxt.ctrl[7:0] = s_r.wdata[7:0];
                  end
                  if (s_r.wstrb[1]) begin
                     s_nxt.ctrl[CTRL_WIDTH-1:8] = s_r.wdata[CTRL_WIDTH-1:8];
                  end
               end else if (s_r.awaddr == OFS_FAULT || s_r.awaddr == OFS_ACTION
                  || s_r.awaddr == OFS_CHAN_ALM || s_r.awaddr == OFS_BLOCK) begin
                  s_nxt.resp = 2'h0;
               end
            end else if (s_axi_arvalid) begin
               s_nxt.ax = AX_RDATA;
               s_nxt.resp = 2'h0;
               case (s_axi_araddr)
                  OFS_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
                  OFS_FAULT: s_nxt.rdata = 32'(fault_v);
                  OFS_ACTION: s_nxt.rdata = {24'h000000, s_r.src, fa.pilot_cut,
                     s_r.local_alm, fa.ais_send, fa.remote_alarm, fa.prompt_alarm, 1'b0};
                  OFS_CHAN_ALM: s_nxt.rdata = {8'h00, sy[NSYNC-1:15]};
                  OFS_BLOCK: s_nxt.rdata = {8'h00, fa.block_pcm_fdm | fa.block_fdm_pcm};
                  default: begin
                     s_nxt.rdata = 32'h00000000;
                     s_nxt.resp = 2'h2;
                  end
               endcase
            end
         end
         AX_WRESP: begin
            if (s_axi_bready) begin
               s_nxt.ax = AX_IDLE;
            end
         end
         AX_RDATA: begin
            if (s_axi_rready) begin
               s_nxt.ax = AX_IDLE;
            end
         end
         default: s_nxt.ax = AX_IDLE;
      endcase
      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.ctrl = CTRL_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign s_axi_awready = ~s_r.aw_got & (s_r.ax == AX_IDLE);
   assign s_axi_wready = ~s_r.w_got & (s_r.ax == AX_IDLE);
   assign s_axi_arready = (s_r.ax == AX_IDLE) & ~(s_r.aw_got & s_r.w_got);
   assign s_axi_bvalid = (s_r.ax == AX_WRESP);
   assign s_axi_bresp = s_r.resp;
   assign s_axi_rvalid = (s_r.ax == AX_RDATA);
   assign s_axi_rresp = s_r.resp;
   assign s_axi_rdata = s_r.rdata;

   // Peer-like behaviour comes from the matrix outputs driven straight to pins.
   assign prompt_alarm = fa.prompt_alarm;
   assign remote_alarm_dl = fa.remote_alarm;
   assign ais_send = fa.ais_send;
   assign block_pcm_fdm = fa.block_pcm_fdm;
   assign block_fdm_pcm = fa.block_fdm_pcm;
   assign pilot_cut = fa.pilot_cut;
   assign local_alarm = s_r.local_alm;
   assign clk_src_sel = s_r.src;

   property p_freerun;
      @(posedge aclk) disable iff (!aresetn)
      (s_r.ctrl[CTRL_SRC_HI:CTRL_SRC_LO] == SRC_EXTERNAL && !ext_ok && !s_r.ctrl[CTRL_TDMA_NOBUF]
         && s_r.ctrl[CTRL_FREERUN_EN]) |=> (clk_src_sel == SRC_FREERUN);
   endproperty
   a_freerun: assert property (p_freerun) else $error("no free-run fallback");

   property p_local;
      @(posedge aclk) disable iff (!aresetn)
      (s_r.ctrl[CTRL_SRC_HI:CTRL_SRC_LO] == SRC_EXTERNAL && !ext_ok) |=> ##1 prompt_alarm;
   endproperty
   a_local: assert property (p_local) else $error("lost reference not alarmed");

   c_free: cover property (@(posedge aclk) disable iff (!aresetn) clk_src_sel == SRC_FREERUN);
   c_rd: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);

endmodule

// file: tb/far_end_model.sv
module far_end_model
(
   // Clock and bench commands
   input wire logic aclk,
   input wire logic [3:0] fail_cmd,
   // Alarm bit sent by the block toward the far end
   input wire logic remote_alarm_dl,
   // Line state as the block receives it, and the alarm bit as the far end sees it
   output logic los_in,
   output logic lof_in,
   output logic rai_in,
   output logic ais_in,
   output logic pcm_lock_in,
   output logic far_alarm_seen
);
   timeunit 1ns;
   timeprecision 1ps;

   // The far terminal slaves its send timing to its receive timing, so lock is never lost.
   assign pcm_lock_in = 1'b1;

   // Line faults change just after an edge, like any real terminal output.
   always @(posedge aclk) begin
      los_in <= fail_cmd[0];
      lof_in <= fail_cmd[1];
      rai_in <= fail_cmd[2];
      ais_in <= fail_cmd[3];
      far_alarm_seen <= remote_alarm_dl;
   end
endmodule

// file: tb/transmultiplexer_unit_tb.sv
module transmultiplexer_unit_tb
   import fault_action_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, fail_cmd = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, clk_src_sel;
   logic err_e4_in = 1'b0, err_e3_in = 1'b0, pilot_level_in = 1'b0, power_fail_in = 1'b0;
   logic system_fail_in = 1'b0, sync_fault_in = 1'b0, ext_ref_present_in = 1'b1;
   logic tdma_sync_present_in = 1'b1;
   logic [1:0] pilot_absent_in = 2'h0;
   logic [23:0] chan_alarm_in = 24'h000000, block_pcm_fdm, block_fdm_pcm;
   logic los_in, lof_in, rai_in, ais_in, pcm_lock_in, far_alarm_seen;
   logic prompt_alarm, remote_alarm_dl, ais_send, pilot_cut, local_alarm;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;

   always #12.5 aclk = ~aclk;

   far_end_model far_u (.aclk(aclk), .fail_cmd(fail_cmd), .remote_alarm_dl(remote_alarm_dl),
      .los_in(los_in), .lof_in(lof_in), .rai_in(rai_in), .ais_in(ais_in),
      .pcm_lock_in(pcm_lock_in), .far_alarm_seen(far_alarm_seen));

   transmultiplexer_unit dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .los_in(los_in), .lof_in(lof_in), .err_e4_in(err_e4_in), .err_e3_in(err_e3_in),
      .rai_in(rai_in), .ais_in(ais_in), .pilot_absent_in(pilot_absent_in),
      .pilot_level_in(pilot_level_in), .power_fail_in(power_fail_in),
      .system_fail_in(system_fail_in), .sync_fault_in(sync_fault_in),
      .ext_ref_present_in(ext_ref_present_in), .pcm_lock_in(pcm_lock_in),
      .tdma_sync_present_in(tdma_sync_present_in), .chan_alarm_in(chan_alarm_in),
      .prompt_alarm(prompt_alarm), .remote_alarm_dl(remote_alarm_dl), .ais_send(ais_send),
      .block_pcm_fdm(block_pcm_fdm), .block_fdm_pcm(block_fdm_pcm), .pilot_cut(pilot_cut),
      .local_alarm(local_alarm), .clk_src_sel(clk_src_sel));

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task final_report();
      $display("Comparisons: %0d, mismatches: %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hung handshake would stall forever; the whole run needs well under this many cycles.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   // Ready and valid come from registered state, so the value at the falling edge is the one
   // the next rising edge sees; sampling there avoids a race with the edge's own updates.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_ok = awvalid && awready;
         w_ok = wvalid && wready;
         b_ok = bvalid;
         if (b_ok) check(bresp, er);
         @(posedge aclk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end while (!b_ok);
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar_ok, r_ok;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_ok = arvalid && arready;
         r_ok = rvalid;
         if (r_ok) check({rdata, rresp}, {ed, er});
         @(posedge aclk);
         if (ar_ok) arvalid <= 1'b0;
      end while (!r_ok);
      rready <= 1'b0;
   endtask

   // Flags are {prompt, remote, ais, pilot cut, local}; the wait covers model and sync delay.
   task automatic expect_out(input logic [4:0] f, input logic [23:0] bp, input logic [23:0] bf);
      repeat (7) @(posedge aclk);
      @(negedge aclk);
      check({prompt_alarm, remote_alarm_dl, ais_send, pilot_cut, local_alarm, block_pcm_fdm,
         block_fdm_pcm}, {f, bp, bf});
      @(posedge aclk);
   endtask

   task t_reset();
      axi_rd(OFS_CTRL, 32'h0000_0004, 2'h0);
      axi_rd(OFS_ACTION, 32'h0000_0000, 2'h0);
      axi_rd(8'h20, 32'h0000_0000, 2'h2);
      axi_wr(OFS_FAULT, 32'hFFFF_FFFF, 2'h0);
      axi_rd(OFS_FAULT, 32'h0000_0000, 2'h0);
      expect_out(5'h00, 24'h000000, 24'h000000);
   endtask

   task t_pcm_loss();
      fail_cmd <= 4'h1;
      expect_out(5'h18, 24'hFFFFFF, 24'h000000);
      check(far_alarm_seen, 1'b1);
      axi_rd(OFS_FAULT, 32'h0000_0001, 2'h0);
      axi_rd(OFS_ACTION, 32'h0000_0006, 2'h0);
      fail_cmd <= 4'h2;
      expect_out(5'h18, 24'hFFFFFF, 24'h000000);
      fail_cmd <= 4'h0;
      expect_out(5'h00, 24'h000000, 24'h000000);
   endtask

   task t_errors();
      err_e3_in <= 1'b1;
      expect_out(5'h00, 24'h000000, 24'h000000);
      err_e4_in <= 1'b1;
      expect_out(5'h18, 24'h000000, 24'h000000);
      err_e4_in <= 1'b0;
      axi_wr(OFS_CTRL, 32'h0000_0804, 2'h0);
      expect_out(5'h18, 24'h000000, 24'h000000);
      err_e3_in <= 1'b0;
      expect_out(5'h00, 24'h000000, 24'h000000);
   endtask

   task t_rai_ais();
      axi_wr(OFS_CTRL, 32'h0000_0004, 2'h0);
      fail_cmd <= 4'h4;
      expect_out(5'h10, 24'h000000, 24'h000000);
      fail_cmd <= 4'h8;
      expect_out(5'h00, 24'h000000, 24'h000000);
      axi_wr(OFS_CTRL, 32'h0000_0014, 2'h0);
      expect_out(5'h10, 24'hFFFFFF, 24'h000000);
      fail_cmd <= 4'h9;
      expect_out(5'h18, 24'hFFFFFF, 24'h000000);
      fail_cmd <= 4'h0;
      axi_wr(OFS_CTRL, 32'h0000_0004, 2'h0);
      expect_out(5'h00, 24'h000000, 24'h000000);
   endtask

   task t_pilot();
      pilot_absent_in <= 2'b01;
      expect_out(5'h10, 24'h000000, 24'h000FFF);
      pilot_absent_in <= 2'b10;
      expect_out(5'h10, 24'h000000, 24'hFFF000);
      pilot_absent_in <= 2'b11;
      expect_out(5'h14, 24'h000000, 24'hFFFFFF);
      pilot_absent_in <= 2'b01;
      chan_alarm_in <= 24'h7FF000;
      expect_out(5'h10, 24'h000000, 24'h000FFF);
      chan_alarm_in <= 24'hFFF000;
      expect_out(5'h14, 24'h000000, 24'h000FFF);
      pilot_absent_in <= 2'b00;
      chan_alarm_in <= 24'hFFFFFF;
      expect_out(5'h04, 24'h000000, 24'h000000);
      chan_alarm_in <= 24'h000000;
      pilot_level_in <= 1'b1;
      expect_out(5'h00, 24'h000000, 24'h000000);
      axi_wr(OFS_CTRL, 32'h0000_000C, 2'h0);
      expect_out(5'h10, 24'h000000, 24'h000000);
      pilot_level_in <= 1'b0;
   endtask

   task t_system();
      axi_wr(OFS_CTRL, 32'h0000_0004, 2'h0);
      power_fail_in <= 1'b1;
      expect_out(5'h10, 24'h000000, 24'h000000);
      axi_wr(OFS_CTRL, 32'h0000_0404, 2'h0);
      expect_out(5'h12, 24'h000000, 24'h000000);
      power_fail_in <= 1'b0;
      system_fail_in <= 1'b1;
      expect_out(5'h10, 24'h000000, 24'h000000);
      axi_wr(OFS_CTRL, 32'h0000_03C4, 2'h0);
      expect_out(5'h1E, 24'hFFFFFF, 24'hFFFFFF);
      system_fail_in <= 1'b0;
      expect_out(5'h00, 24'h000000, 24'h000000);
   endtask

   task t_sync();
      axi_wr(OFS_CTRL, 32'h0000_0005, 2'h0);
      expect_out(5'h00, 24'h000000, 24'h000000);
      check(clk_src_sel, SRC_EXTERNAL);
      ext_ref_present_in <= 1'b0;
      expect_out(5'h11, 24'h000000, 24'h000000);
      check(clk_src_sel, SRC_FREERUN);
      ext_ref_present_in <= 1'b1;
      sync_fault_in <= 1'b1;
      expect_out(5'h11, 24'h000000, 24'h000000);
      sync_fault_in <= 1'b0;
      axi_wr(OFS_CTRL, 32'h0000_0006, 2'h0);
      expect_out(5'h00, 24'h000000, 24'h000000);
      check(clk_src_sel, SRC_PCM);
      axi_wr(OFS_CTRL, 32'h0000_0024, 2'h0);
      expect_out(5'h00, 24'h000000, 24'h000000);
      check(clk_src_sel, SRC_EXTERNAL);
      tdma_sync_present_in <= 1'b0;
      expect_out(5'h11, 24'h000000, 24'h000000);
      check(clk_src_sel, SRC_FREERUN);
      tdma_sync_present_in <= 1'b1;
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_pcm_loss();
      t_errors();
      t_rai_ais();
      t_pilot();
      t_system();
      t_sync();
      final_report();
   end
endmodule
